// File: logic/scs_map.svh
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH
// register byte offsets
`define SCS_OFF_OSC_CTRL 8'h00
`define SCS_OFF_T1_CTRL 8'h04
`define SCS_OFF_CONFIG 8'h08
`define SCS_OFF_STATUS 8'h0c
`define SCS_OFF_PORT_A_INPUT_LAT 8'h10
`define SCS_OFF_PORT_A_INPUT_DIR 8'h14
`define SCS_OFF_PORT_A_INPUT_IN 8'h18
// field positions
`define SCS_BIT_CLK_SEL 0
`define SCS_BIT_T1_OSC_EN 3
`define SCS_BIT_PERMIT_N 3
`define SCS_BIT_PORT_A_INPUT_FREE 6
// reset values
`define SCS_RST_OSC_CTRL 8'h00
`define SCS_RST_T1_CTRL 8'h00
`define SCS_RST_CONFIG 8'h08
`define SCS_RST_PORT_A_INPUT_LAT 8'h00
`define SCS_RST_PORT_A_INPUT_DIR 8'hff
// mode codes, arbitrary order
`define SCS_CODE_LP 3'h0
`define SCS_CODE_XT 3'h1
`define SCS_CODE_HS 3'h2
`define SCS_CODE_HSM 3'h3
`define SCS_CODE_RC 3'h4
`define SCS_CODE_RCF 3'h5
`define SCS_CODE_EC 3'h6
`define SCS_CODE_ECF 3'h7
`endif

// File: logic/scs_pkg.sv
`default_nettype none
package scs_pkg;
  typedef enum logic [2:0] {
    SCS_SRC_CRYSTAL = 3'b000,
    SCS_SRC_PLL = 3'b001,
    SCS_SRC_RC = 3'b010,
    SCS_SRC_EXT = 3'b011,
    SCS_SRC_SECONDARY = 3'b100
  } scs_src_e;
  typedef struct packed {
    logic pin_free;
    logic use_pll;
    scs_src_e src;
  } scs_route_s;
endpackage
`default_nettype wire

// File: logic/scs_mode_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "scs_map.svh"
module scs_mode_decode
  import scs_pkg::*;
#(
  parameter logic [2:0] CODE_LP = `SCS_CODE_LP,
  parameter logic [2:0] CODE_XT = `SCS_CODE_XT,
  parameter logic [2:0] CODE_HS = `SCS_CODE_HS,
  parameter logic [2:0] CODE_HSM = `SCS_CODE_HSM,
  parameter logic [2:0] CODE_RC = `SCS_CODE_RC,
  parameter logic [2:0] CODE_RCF = `SCS_CODE_RCF,
  parameter logic [2:0] CODE_EC = `SCS_CODE_EC,
  parameter logic [2:0] CODE_ECF = `SCS_CODE_ECF
)(
  // mode field and selected source
  input wire logic [2:0] mode_i,
  input wire logic sel_secondary_i,
  output scs_route_s route_o
);
  always_comb
  begin
    route_o = '{pin_free: 1'b0, use_pll: 1'b0, src: SCS_SRC_CRYSTAL};
    if (mode_i == CODE_HSM)
    begin
      route_o.use_pll = 1'b1;
      route_o.src = SCS_SRC_PLL;
    end
    else if (mode_i == CODE_RC || mode_i == CODE_RCF)
    begin
      route_o.src = SCS_SRC_RC;
    end
    else if (mode_i == CODE_EC || mode_i == CODE_ECF)
    begin
      route_o.src = SCS_SRC_EXT;
    end
    // lp, xt, hs use the oscillator directly
    route_o.pin_free = (mode_i == CODE_RCF) || (mode_i == CODE_ECF);
    if (sel_secondary_i)
    begin
      route_o.src = SCS_SRC_SECONDARY;
    end
  end
endmodule
`default_nettype wire

// File: logic/scs_clock_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "scs_map.svh"
module scs_clock_select
  import scs_pkg::*;
#(
  parameter logic [2:0] CODE_LP = `SCS_CODE_LP,
  parameter logic [2:0] CODE_XT = `SCS_CODE_XT,
  parameter logic [2:0] CODE_HS = `SCS_CODE_HS,
  parameter logic [2:0] CODE_HSM = `SCS_CODE_HSM,
  parameter logic [2:0] CODE_RC = `SCS_CODE_RC,
  parameter logic [2:0] CODE_RCF = `SCS_CODE_RCF,
  parameter logic [2:0] CODE_EC = `SCS_CODE_EC,
  parameter logic [2:0] CODE_ECF = `SCS_CODE_ECF
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // port a bit 6 pin
  input wire logic porta6_pin_i,
  output logic porta6_o,
  output logic porta6_oe_o,
  // clock routing
  output logic secondary_osc_enable_o,
  output logic use_pll_o,
  output logic osc_output_pin_free_o,
  output scs_src_e clk_src_o
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic clock_select_bit;
  logic clock_select_active;
  logic [7:0] timer1_control;
  logic [7:0] config_reg;
  logic port_a_latch6;
  logic port_a_dir6;
  logic [2:0] primary_mode_cfg;
  logic switch_permit_cfg_n;
  logic secondary_osc_enable;
  logic switch_allowed;
  logic req;
  logic wr;
  logic hit;
  scs_route_s route;

  assign primary_mode_cfg = config_reg[2:0];
  assign switch_permit_cfg_n = config_reg[`SCS_BIT_PERMIT_N];
  assign secondary_osc_enable = timer1_control[`SCS_BIT_T1_OSC_EN];
  assign switch_allowed = !switch_permit_cfg_n && secondary_osc_enable;
  // routing sees the gated bit so a lost permission acts at once
  assign clock_select_active = clock_select_bit && switch_allowed;
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign wr = req && we_i && sel_i[0];

  always_comb
  begin
    hit = 1'b1;
    case (adr_i)
      `SCS_OFF_OSC_CTRL, `SCS_OFF_T1_CTRL, `SCS_OFF_CONFIG, `SCS_OFF_STATUS,
      `SCS_OFF_PORT_A_INPUT_LAT, `SCS_OFF_PORT_A_INPUT_DIR, `SCS_OFF_PORT_A_INPUT_IN: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // bus answer, one cycle after the request
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end
    else
    begin
      ack_o <= req && hit;
      err_o <= req && !hit;
    end
  end

  // ----------------------------------------
  // clock select bit
  // ----------------------------------------
  // a write only sets the bit when switching is permitted; losing
  // permission later clears it at the next clock edge; the gated bit brings the primary clock back at once
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clock_select_bit <= 1'b0;
    end
    else if (!switch_allowed)
    begin
      clock_select_bit <= 1'b0;
    end
    else if (wr && hit && adr_i == `SCS_OFF_OSC_CTRL)
    begin
      clock_select_bit <= dat_i[`SCS_BIT_CLK_SEL];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer1_control <= `SCS_RST_T1_CTRL;
    end
    else if (wr && adr_i == `SCS_OFF_T1_CTRL)
    begin
      timer1_control <= dat_i[7:0];
    end
  end

  // configuration stands in for the non-volatile bits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      config_reg <= `SCS_RST_CONFIG;
    end
    else if (wr && adr_i == `SCS_OFF_CONFIG)
    begin
      config_reg <= dat_i[7:0];
    end
  end

  // ----------------------------------------
  // port a bit 6
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_a_latch6 <= 1'(`SCS_RST_PORT_A_INPUT_LAT >> `SCS_BIT_PORT_A_INPUT_FREE);
      port_a_dir6 <= 1'(`SCS_RST_PORT_A_INPUT_DIR >> `SCS_BIT_PORT_A_INPUT_FREE);
    end
    else if (!route.pin_free)
    begin
      port_a_latch6 <= 1'b0;
      port_a_dir6 <= 1'b1;
    end
    else if (wr && adr_i == `SCS_OFF_PORT_A_INPUT_LAT)
    begin
      port_a_latch6 <= dat_i[`SCS_BIT_PORT_A_INPUT_FREE];
    end
    else if (wr && adr_i == `SCS_OFF_PORT_A_INPUT_DIR)
    begin
      port_a_dir6 <= dat_i[`SCS_BIT_PORT_A_INPUT_FREE];
    end
  end

  assign porta6_o = port_a_latch6;
  assign porta6_oe_o = route.pin_free && !port_a_dir6;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_o <= 32'h0000_0000;
    end
    else if (req && !we_i)
    begin
      dat_o <= 32'h0000_0000;
      case (adr_i)
        `SCS_OFF_OSC_CTRL: dat_o[0] <= clock_select_active;
        `SCS_OFF_T1_CTRL: dat_o[7:0] <= timer1_control;
        `SCS_OFF_CONFIG: dat_o[7:0] <= config_reg;
        `SCS_OFF_STATUS: dat_o[5:0] <= {route.pin_free, route.use_pll, switch_allowed, route.src};
        `SCS_OFF_PORT_A_INPUT_LAT: dat_o[6] <= route.pin_free && port_a_latch6;
        `SCS_OFF_PORT_A_INPUT_DIR: dat_o[6] <= route.pin_free && port_a_dir6;
        `SCS_OFF_PORT_A_INPUT_IN: dat_o[6] <= route.pin_free && porta6_pin_i;
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // source routing
  // ----------------------------------------
  scs_mode_decode #(
    .CODE_LP(CODE_LP),
    .CODE_XT(CODE_XT),
    .CODE_HS(CODE_HS),
    .CODE_HSM(CODE_HSM),
    .CODE_RC(CODE_RC),
    .CODE_RCF(CODE_RCF),
    .CODE_EC(CODE_EC),
    .CODE_ECF(CODE_ECF)
  ) u_decode (
    .mode_i(primary_mode_cfg),
    .sel_secondary_i(clock_select_active),
    .route_o(route)
  );

  assign secondary_osc_enable_o = secondary_osc_enable;
  assign use_pll_o = route.use_pll;
  assign osc_output_pin_free_o = route.pin_free;
  assign clk_src_o = route.src;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // bus answer checks
  // ----------------------------------------
  AST_ACK_NEXT: assert property ((req && hit) |=> ack_o && !err_o)
    else $error("mapped access not acknowledged");

  AST_ERR_NEXT: assert property ((req && !hit) |=> err_o && !ack_o)
    else $error("unmapped access not refused");

  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("acknowledge held too long");

  AST_OSC_RD: assert property ((req && !we_i && adr_i == `SCS_OFF_OSC_CTRL)
    |=> ack_o && dat_o[31:1] == 31'h0)
    else $error("unimplemented bits read nonzero");

  AST_OSC_RD_BIT: assert property ((req && !we_i && adr_i == `SCS_OFF_OSC_CTRL)
    |=> dat_o[0] == $past(clock_select_active))
    else $error("select bit read back wrong");

  // ----------------------------------------
  // select bit checks
  // ----------------------------------------
  AST_SEL_NEEDS_PERMIT: assert property (clk_src_o == SCS_SRC_SECONDARY |-> switch_allowed)
    else $error("secondary routed without permission");

  AST_NO_T1_PRIMARY: assert property (!secondary_osc_enable_o |-> clk_src_o != SCS_SRC_SECONDARY)
    else $error("secondary routed while disabled");

  AST_PERMIT_N_PRIMARY: assert property (switch_permit_cfg_n |-> clk_src_o != SCS_SRC_SECONDARY)
    else $error("secondary routed while not permitted");

  AST_SEL_WRITE: assert property ((wr && hit && adr_i == `SCS_OFF_OSC_CTRL && switch_allowed)
    ##1 switch_allowed |-> clock_select_bit == $past(dat_i[0]))
    else $error("select write not taken");

  AST_SEL_HELD_LOW: assert property (!switch_allowed |=> !clock_select_bit)
    else $error("select bit not held low");

  AST_RESET_CLEAR: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> !clock_select_bit)
    else $error("reset left select set");

  AST_RESET_ROUTE: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> clk_src_o != SCS_SRC_SECONDARY)
    else $error("reset left secondary routed");

  AST_T1_WRITE: assert property ((wr && adr_i == `SCS_OFF_T1_CTRL)
    |=> secondary_osc_enable_o == $past(dat_i[`SCS_BIT_T1_OSC_EN]))
    else $error("secondary enable write not taken");

  // ----------------------------------------
  // routing checks
  // ----------------------------------------
  AST_SRC_SECONDARY: assert property (clock_select_active |-> clk_src_o == SCS_SRC_SECONDARY)
    else $error("secondary not routed");

  AST_SRC_PRIMARY: assert property (!clock_select_active |-> clk_src_o != SCS_SRC_SECONDARY)
    else $error("primary not routed");

  AST_PLL: assert property (use_pll_o == (primary_mode_cfg == CODE_HSM))
    else $error("pll use wrong");

  AST_XTAL_DIRECT: assert property ((!clock_select_active && (primary_mode_cfg == CODE_LP ||
    primary_mode_cfg == CODE_XT || primary_mode_cfg == CODE_HS)) |-> clk_src_o == SCS_SRC_CRYSTAL)
    else $error("crystal not routed direct");

  AST_PLL_SRC: assert property ((!clock_select_active && primary_mode_cfg == CODE_HSM)
    |-> clk_src_o == SCS_SRC_PLL)
    else $error("pll not routed");

  AST_RC_SRC: assert property ((!clock_select_active && (primary_mode_cfg == CODE_RC ||
    primary_mode_cfg == CODE_RCF)) |-> clk_src_o == SCS_SRC_RC)
    else $error("rc not routed");

  AST_EC_SRC: assert property ((!clock_select_active && (primary_mode_cfg == CODE_EC ||
    primary_mode_cfg == CODE_ECF)) |-> clk_src_o == SCS_SRC_EXT)
    else $error("external clock not routed");

  AST_PIN_FREE: assert property (osc_output_pin_free_o ==
    (primary_mode_cfg == CODE_RCF || primary_mode_cfg == CODE_ECF))
    else $error("pin release wrong");

  // ----------------------------------------
  // port a bit 6 checks
  // ----------------------------------------
  AST_PORT_A_INPUT_OFF: assert property (!osc_output_pin_free_o |-> !porta6_oe_o)
    else $error("port bit driven in dedicated mode");

  AST_PORT_A_INPUT_LATCH_OFF: assert property (!osc_output_pin_free_o |=> !porta6_o)
    else $error("port latch kept in dedicated mode");

  AST_PORT_A_INPUT_RD_OFF: assert property ((req && !we_i && !osc_output_pin_free_o &&
    (adr_i == `SCS_OFF_PORT_A_INPUT_LAT || adr_i == `SCS_OFF_PORT_A_INPUT_DIR || adr_i == `SCS_OFF_PORT_A_INPUT_IN)) |=> dat_o == 32'h0)
    else $error("port bit read nonzero in dedicated mode");

  AST_PORT_A_INPUT_DRIVE: assert property ((osc_output_pin_free_o && !port_a_dir6) |-> porta6_oe_o)
    else $error("freed pin not driven");

  AST_PORT_A_INPUT_LATCH_WR: assert property ((osc_output_pin_free_o && wr && adr_i == `SCS_OFF_PORT_A_INPUT_LAT)
    |=> porta6_o == $past(dat_i[`SCS_BIT_PORT_A_INPUT_FREE]))
    else $error("port latch write not taken");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  COV_SWITCH: cover property (!clock_select_bit ##1 clock_select_bit);
  COV_DROP: cover property (clock_select_bit ##1 !clock_select_bit);
  COV_PLL: cover property (use_pll_o);
  COV_ERR: cover property (err_o);
  COV_PIN_DRIVE: cover property (porta6_oe_o);
endmodule
`default_nettype wire

// File: tb/scs_pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// pin partner
// ----------
module scs_pin_partner (
  // clock and pin sides
  input wire logic clk_i,
  input wire logic oe_i,
  input wire logic dut_i,
  input wire logic drive_i,
  input wire logic val_i,
  output logic pin_o
);
  logic tog;
  initial tog = 1'b0;
  // floating pin shows no stale level
  always @(posedge clk_i)
    tog <= ~tog;
  assign pin_o = oe_i ? dut_i : (drive_i ? val_i : tog);
endmodule
`default_nettype wire

// File: tb/scs_clock_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scs_map.svh"
// ----------
// bench
// ----------
module scs_clock_select_tb_top;
  import scs_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, err, e, p6, p6oe, pin, t1en, pll, pfree, drv, val;
  logic [7:0] adr;
  logic [31:0] dat, rd, dat_o;
  scs_src_e src;
  int n_errors = 0;
  int n_tests = 0;
  scs_clock_select u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .err_o(err),
    .porta6_pin_i(pin), .porta6_o(p6), .porta6_oe_o(p6oe), .secondary_osc_enable_o(t1en),
    .use_pll_o(pll), .osc_output_pin_free_o(pfree), .clk_src_o(src));
  scs_pin_partner u_pin (.clk_i(clk_i), .oe_i(p6oe), .dut_i(p6), .drive_i(drv), .val_i(val), .pin_o(pin));
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic print_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, x, g);
    end
  endtask
  // one classic cycle, waits for ack or err
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    k = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      k++;
    end
    while (ack !== 1'b1 && err !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      n_errors++;
      print_verdict();
    end
    rd = dat_o;
    e = err;
    @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 8'h00);
    chk(nm, x, rd);
  endtask
  task automatic t_reset;
    rc("osc", `SCS_OFF_OSC_CTRL, 32'h0);
    rc("cfg", `SCS_OFF_CONFIG, 32'h8);
    chk("t1en", 32'h0, 32'(t1en));
    chk("src", 32'(SCS_SRC_CRYSTAL), 32'(src));
    $display("test reset done");
  endtask
  task automatic t_switch;
    wb(1'b1, `SCS_OFF_OSC_CTRL, 8'h01);
    rc("osc", `SCS_OFF_OSC_CTRL, 32'h0);
    wb(1'b1, `SCS_OFF_T1_CTRL, 8'h08);
    chk("t1en", 32'h1, 32'(t1en));
    wb(1'b1, `SCS_OFF_OSC_CTRL, 8'h01);
    rc("osc", `SCS_OFF_OSC_CTRL, 32'h0);
    wb(1'b1, `SCS_OFF_CONFIG, 8'h00);
    wb(1'b1, `SCS_OFF_OSC_CTRL, 8'hff);
    rc("osc", `SCS_OFF_OSC_CTRL, 32'h1);
    chk("src", 32'(SCS_SRC_SECONDARY), 32'(src));
    rc("status", `SCS_OFF_STATUS, 32'h0c);
    wb(1'b1, `SCS_OFF_CONFIG, 8'h08);
    rc("osc", `SCS_OFF_OSC_CTRL, 32'h0);
    wb(1'b1, `SCS_OFF_CONFIG, 8'h00);
    wb(1'b1, `SCS_OFF_OSC_CTRL, 8'h01);
    wb(1'b1, `SCS_OFF_T1_CTRL, 8'h00);
    rc("osc", `SCS_OFF_OSC_CTRL, 32'h0);
    wb(1'b1, `SCS_OFF_T1_CTRL, 8'h08);
    wb(1'b1, `SCS_OFF_OSC_CTRL, 8'h01);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rc("osc", `SCS_OFF_OSC_CTRL, 32'h0);
    wb(1'b1, `SCS_OFF_CONFIG, 8'h00);
    wb(1'b1, `SCS_OFF_T1_CTRL, 8'h08);
    rc("osc", `SCS_OFF_OSC_CTRL, 32'h0);
    chk("src", 32'(SCS_SRC_CRYSTAL), 32'(src));
    $display("test switch done");
  endtask
  task automatic t_modes;
    scs_src_e xs[8] = '{SCS_SRC_CRYSTAL, SCS_SRC_CRYSTAL, SCS_SRC_CRYSTAL, SCS_SRC_PLL,
      SCS_SRC_RC, SCS_SRC_RC, SCS_SRC_EXT, SCS_SRC_EXT};
    logic pf;
    for (int m = 0; m < 8; m++)
    begin
      pf = (m == 5 || m == 7);
      wb(1'b1, `SCS_OFF_CONFIG, 8'h08 | 8'(m));
      chk("src", 32'(xs[m]), 32'(src));
      chk("pll", 32'(m == 3), 32'(pll));
      chk("pfree", 32'(pf), 32'(pfree));
      drv <= 1'b1;
      val <= 1'b1;
      wb(1'b1, `SCS_OFF_PORT_A_INPUT_LAT, 8'h40);
      wb(1'b1, `SCS_OFF_PORT_A_INPUT_DIR, 8'h40);
      rc("pin", `SCS_OFF_PORT_A_INPUT_IN, pf ? 32'h40 : 32'h0);
      rc("lat", `SCS_OFF_PORT_A_INPUT_LAT, pf ? 32'h40 : 32'h0);
      drv <= 1'b0;
      wb(1'b1, `SCS_OFF_PORT_A_INPUT_DIR, 8'h00);
      chk("oe", 32'(pf), 32'(p6oe));
      chk("p6", 32'(pf), 32'(p6));
      rc("drv", `SCS_OFF_PORT_A_INPUT_IN, pf ? 32'h40 : 32'h0);
    end
    $display("test modes done");
  endtask
  task automatic t_unmapped;
    wb(1'b1, 8'h1c, 8'hff);
    chk("err", 32'h1, 32'(e));
    $display("test unmapped done");
  endtask
  initial
  begin
    #200000;
    n_errors++;
    print_verdict();
  end
  initial
  begin
    rst_i = 1'b1;
    {cyc, stb, we, drv, val} = 5'h00;
    adr = 8'h00;
    dat = 32'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_switch();
    t_modes();
    t_unmapped();
    print_verdict();
  end
endmodule
`default_nettype wire
